//--- rtl/slrc_top.sv
// Serial link reset controller: one or two link pairs, AXI4-Lite registers.
// Assumes frame indications are synchronous to aclk with a per-frame strobe.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "slrc_defines.svh"
module slrc_top #(
  parameter int unsigned PAIRS = 2
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [PAIRS-1:0]   frame_valid,
  input  wire logic [PAIRS-1:0]   data_frame_seen,
  input  wire logic [PAIRS-1:0]   square_fill_seen,
  input  wire logic [PAIRS-1:0]   ready_fill_seen,
  input  wire logic [PAIRS-1:0]   frame_error_seen,
  input  wire logic [PAIRS-1:0]   tx_multiplier_unlocked,
  output logic [PAIRS-1:0]        tx_select_square_fill,
  output logic [PAIRS-1:0]        tx_select_ready_fill,
  output logic [PAIRS-1:0]        tx_select_data,
  input  wire logic [PAIRS-1:0]   hs_in_connect,
  input  wire logic [PAIRS-1:0]   hs_in_ready,
  output logic [PAIRS-1:0]        hs_out_connect,
  output logic [PAIRS-1:0]        hs_out_ready,
  output logic [PAIRS-1:0]        hs_in_connect_gated,
  output logic [PAIRS-1:0]        hs_in_ready_gated,
  output logic                    irq,
  input  wire logic [31:0]        s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output logic                    s_axil_awready,
  input  wire logic [31:0]        s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output logic                    s_axil_wready,
  output logic [1:0]              s_axil_bresp,
  output logic                    s_axil_bvalid,
  input  wire logic               s_axil_bready,
  input  wire logic [31:0]        s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output logic                    s_axil_arready,
  output logic [31:0]             s_axil_rdata,
  output logic [1:0]              s_axil_rresp,
  output logic                    s_axil_rvalid,
  input  wire logic               s_axil_rready
);
  localparam int unsigned EVW = `SLRC_EV_NUM * PAIRS;

  logic [31:0]        ctrl_q;
  logic [EVW-1:0]     stat_q;
  logic [EVW-1:0]     mask_q;
  logic [EVW-1:0]     events;
  logic [PAIRS-1:0]   conn_ready_en;
  logic [PAIRS-1:0]   hs_en;
  logic [PAIRS-1:0]   err_reset;
  logic [PAIRS-1:0]   fe_prev_q;
  logic [PAIRS-1:0]   rd_prev_q;
  logic [PAIRS-1:0]   dt_prev_q;
  logic [PAIRS-1:0]   restart;
  logic [PAIRS-1:0]   sel_sq_q;
  logic [PAIRS-1:0]   sel_rd_q;
  logic [PAIRS-1:0]   sel_dt_q;
  logic [2*PAIRS-1:0] state_bits;
  slrc_pkg::slrc_state_t state_w [PAIRS];

  // Independent controller and debouncer per link pair.
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    slrc_frame_if fr ();
    assign fr.frame_valid      = frame_valid[p];
    // Inputs are one-hot per frame; error has priority if the source slips.
    assign fr.frame_error_seen = frame_error_seen[p];
    assign fr.data_frame_seen  = data_frame_seen[p] & ~frame_error_seen[p];
    assign fr.square_fill_seen = square_fill_seen[p] & ~frame_error_seen[p];
    assign fr.ready_fill_seen  = ready_fill_seen[p] & ~frame_error_seen[p];
    slrc_debounce u_deb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fr      (fr)
    );
    slrc_link_fsm u_fsm (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .restart                (restart[p]),
      .tx_multiplier_unlocked (tx_multiplier_unlocked[p]),
      .fr                     (fr),
      .state                  (state_w[p]),
      .tx_select_square_fill  (sel_sq_q[p]),
      .tx_select_ready_fill   (sel_rd_q[p]),
      .tx_select_data         (sel_dt_q[p]),
      .hs_enable              (hs_en[p]),
      .conn_ready_enable      (conn_ready_en[p]),
      .err_reset              (err_reset[p])
    );
    assign state_bits[2*p +: 2] = state_w[p];

    // Two frame errors back to back, or software restart, restart the pair.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fe_prev_q[p] <= 1'b0;
      end else if (frame_valid[p]) begin
        fe_prev_q[p] <= frame_error_seen[p];
      end
    end
    assign restart[p] = (frame_valid[p] & frame_error_seen[p] & fe_prev_q[p]) |
                        ctrl_q[p];

    assign events[`SLRC_EV_NUM*p + `SLRC_EV_TO_LOCK]   = err_reset[p] | restart[p];
    // Entry events compare against last cycle's select, which is low out of reset.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rd_prev_q[p] <= 1'b0;
        dt_prev_q[p] <= 1'b0;
      end else begin
        rd_prev_q[p] <= sel_rd_q[p];
        dt_prev_q[p] <= sel_dt_q[p];
      end
    end
    assign events[`SLRC_EV_NUM*p + `SLRC_EV_TO_WAIT]   = sel_rd_q[p] & ~rd_prev_q[p];
    assign events[`SLRC_EV_NUM*p + `SLRC_EV_TO_DATA]   = sel_dt_q[p] & ~dt_prev_q[p];
    assign events[`SLRC_EV_NUM*p + `SLRC_EV_ERR_RESET] = frame_valid[p] & frame_error_seen[p] &
                                                         fe_prev_q[p];
  end

  assign tx_select_square_fill = sel_sq_q;
  assign tx_select_ready_fill  = sel_rd_q;
  assign tx_select_data        = sel_dt_q;
  assign hs_out_connect        = hs_in_connect & conn_ready_en;
  assign hs_out_ready          = hs_in_ready & conn_ready_en;
  assign hs_in_connect_gated   = hs_in_connect & hs_en;
  assign hs_in_ready_gated     = hs_in_ready & hs_en;

  // AXI4-Lite write path: address and data taken in either order.
  logic        aw_held_q;
  logic        w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        stat_wr;

  assign s_axil_awready = !aw_held_q && !s_axil_bvalid;
  assign s_axil_wready  = !w_held_q && !s_axil_bvalid;
  assign do_write       = aw_held_q && w_held_q && !s_axil_bvalid;
  assign stat_wr        = do_write && awaddr_q[31:2] == 30'(`SLRC_OFF_IRQ_STAT >> 2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= 2'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axil_wdata;
        wstrb_q  <= s_axil_wstrb;
      end
      if (do_write) begin
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (awaddr_q[31:2] > (`SLRC_OFF_IRQ_MASK >> 2)) ? 2'h2 : 2'h0;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // Control: low PAIRS bits are one-cycle software restarts of each pair.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SLRC_CTRL_RESET;
    end else if (do_write && awaddr_q[31:2] == (`SLRC_OFF_CTRL >> 2) && wstrb_q[0]) begin
      ctrl_q <= {24'h000000, wdata_q[7:0]};
    end else begin
      ctrl_q <= `SLRC_CTRL_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= EVW'(`SLRC_MASK_RESET);
    end else if (do_write && awaddr_q[31:2] == (`SLRC_OFF_IRQ_MASK >> 2)) begin
      mask_q <= wdata_q[EVW-1:0];
    end
  end

  // Sticky status: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (stat_wr) begin
      stat_q <= (stat_q & ~wdata_q[EVW-1:0]) | events;
    end else begin
      stat_q <= stat_q | events;
    end
  end

  assign irq = |(stat_q & mask_q);

  // AXI4-Lite read path.
  assign s_axil_arready = !s_axil_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h0000_0000;
      s_axil_rresp  <= 2'h0;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp  <= 2'h0;
      case (s_axil_araddr[31:2])
        30'(`SLRC_OFF_CTRL >> 2):     s_axil_rdata <= 32'h0000_0000;
        30'(`SLRC_OFF_STATE >> 2):    s_axil_rdata <= 32'(state_bits);
        30'(`SLRC_OFF_IRQ_STAT >> 2): s_axil_rdata <= 32'(stat_q);
        30'(`SLRC_OFF_IRQ_MASK >> 2): s_axil_rdata <= 32'(mask_q);
        default: begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= 2'h2;
        end
      endcase
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  a_stat_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    |($past(stat_q) & ~stat_q) |-> $past(stat_wr))
    else $error("status bit cleared without a status write");
  a_double_fe: assert property (@(posedge aclk) disable iff (!aresetn)
    restart[0] |=> tx_select_square_fill[0])
    else $error("back-to-back errors did not restart");
endmodule

//--- rtl/slrc_defines.svh
// Timing counts and register map for the serial link reset controller.
// Assumes a 100 MHz aclk; included by bare name.
`ifndef SLRC_DEFINES_SVH
`define SLRC_DEFINES_SVH
`define SLRC_QUAL_FRAMES        128
`define SLRC_SETTLE_NS          20000
`define SLRC_CLK_NS             10
`define SLRC_SETTLE_CYC         ((`SLRC_SETTLE_NS + `SLRC_CLK_NS - 1) / `SLRC_CLK_NS)
`define SLRC_OFF_CTRL           32'h0000_0000
`define SLRC_OFF_STATE          32'h0000_0004
`define SLRC_OFF_IRQ_STAT       32'h0000_0008
`define SLRC_OFF_IRQ_MASK       32'h0000_000C
`define SLRC_CTRL_RESET         32'h0000_0000
`define SLRC_MASK_RESET         32'h0000_0000
`define SLRC_EV_NUM             4
`define SLRC_EV_TO_LOCK         0
`define SLRC_EV_TO_WAIT         1
`define SLRC_EV_TO_DATA         2
`define SLRC_EV_ERR_RESET       3
`endif

//--- rtl/slrc_pkg.sv
// Types shared by the serial link reset controller.
// Assumes slrc_defines.svh supplies the numeric constants.
package slrc_pkg;
  typedef enum logic [1:0] {
    SLRC_ACQUIRE,
    SLRC_WAIT_PEER,
    SLRC_SEND_DATA
  } slrc_state_t;
endpackage

//--- rtl/slrc_frame_if.sv
// Frame indications from one receive deserializer and the debounced results.
// Assumes one indication per received frame, marked by frame_valid.
`timescale 1ns/1ps
interface slrc_frame_if;
  logic frame_valid;
  logic data_frame_seen;
  logic square_fill_seen;
  logic ready_fill_seen;
  logic frame_error_seen;
  logic db_data;
  logic db_square;
  logic db_ready;
  logic db_error;
  modport src (
    output frame_valid, data_frame_seen, square_fill_seen, ready_fill_seen, frame_error_seen,
    input  db_data, db_square, db_ready, db_error
  );
  modport deb (
    input  frame_valid, data_frame_seen, square_fill_seen, ready_fill_seen, frame_error_seen,
    output db_data, db_square, db_ready, db_error
  );
  // The controller only reads; the raw lines are driven by the top directly.
  modport mon (
    input  frame_valid, data_frame_seen, square_fill_seen, ready_fill_seen, frame_error_seen,
           db_data, db_square, db_ready, db_error
  );
endinterface

//--- rtl/slrc_debounce.sv
// Two-frame debouncer for the frame type indications of one link pair.
// Assumes frame_valid pulses once per received frame.
`timescale 1ns/1ps
module slrc_debounce (
  input wire logic aclk,
  input wire logic aresetn,
  slrc_frame_if.deb fr
);
  logic [3:0] prev_q;
  logic [3:0] db_q;
  logic [3:0] cur;

  assign cur = {fr.frame_error_seen, fr.ready_fill_seen, fr.square_fill_seen,
                fr.data_frame_seen};

  // A type counts only when two consecutive frames agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 4'h0;
      db_q   <= 4'h0;
    end else if (fr.frame_valid) begin
      prev_q <= cur;
      db_q   <= prev_q & cur;
    end
  end

  assign fr.db_data   = db_q[0];
  assign fr.db_square = db_q[1];
  assign fr.db_ready  = db_q[2];
  assign fr.db_error  = db_q[3];
endmodule

//--- rtl/slrc_link_fsm.sv
// Reset state machine for one link pair of the serial link reset controller.
// Assumes debounced frame types arrive through slrc_frame_if.
`timescale 1ns/1ps
`include "slrc_defines.svh"
module slrc_link_fsm #(
  parameter int unsigned QUAL_FRAMES = `SLRC_QUAL_FRAMES,
  parameter int unsigned SETTLE_CYC  = `SLRC_SETTLE_CYC
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          restart,
  input  wire logic          tx_multiplier_unlocked,
  slrc_frame_if.mon          fr,
  output slrc_pkg::slrc_state_t state,
  output logic               tx_select_square_fill,
  output logic               tx_select_ready_fill,
  output logic               tx_select_data,
  output logic               hs_enable,
  output logic               conn_ready_enable,
  output logic               err_reset
);
  slrc_pkg::slrc_state_t state_q;
  logic [7:0]  lock_cnt_q;
  logic [7:0]  qual_cnt_q;
  logic [15:0] settle_q;
  logic        err_cond;

  assign err_cond = tx_multiplier_unlocked | fr.db_error;
  assign state    = state_q;
  assign err_reset = (state_q != slrc_pkg::SLRC_ACQUIRE) &&
                     (err_cond || fr.db_square);

  // Lock hold: frames of square fill sent since the multiplier locked.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != slrc_pkg::SLRC_ACQUIRE || tx_multiplier_unlocked) begin
      lock_cnt_q <= 8'h00;
    end else if (fr.frame_valid && lock_cnt_q != QUAL_FRAMES[7:0]) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  // Receive qualification: clean debounced fill frames, restarted by any frame error.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != slrc_pkg::SLRC_ACQUIRE) begin
      qual_cnt_q <= 8'h00;
    end else if (fr.frame_valid) begin
      if (fr.frame_error_seen || fr.db_error || !(fr.db_square || fr.db_ready)) begin
        qual_cnt_q <= 8'h00;
      end else if (qual_cnt_q != QUAL_FRAMES[7:0]) begin
        qual_cnt_q <= qual_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      state_q <= slrc_pkg::SLRC_ACQUIRE;
    end else begin
      case (state_q)
        slrc_pkg::SLRC_ACQUIRE: begin
          if (lock_cnt_q == QUAL_FRAMES[7:0] && qual_cnt_q == QUAL_FRAMES[7:0] &&
              !err_cond) begin
            state_q <= slrc_pkg::SLRC_WAIT_PEER;
          end
        end
        slrc_pkg::SLRC_WAIT_PEER: begin
          if (err_reset) begin
            state_q <= slrc_pkg::SLRC_ACQUIRE;
          end else if (fr.db_ready || fr.data_frame_seen && fr.db_data) begin
            state_q <= slrc_pkg::SLRC_SEND_DATA;
          end
        end
        slrc_pkg::SLRC_SEND_DATA: begin
          if (err_reset) begin
            state_q <= slrc_pkg::SLRC_ACQUIRE;
          end
        end
        default: state_q <= slrc_pkg::SLRC_ACQUIRE;
      endcase
    end
  end

  // Settle timer after entering the data state.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != slrc_pkg::SLRC_SEND_DATA) begin
      settle_q <= 16'h0000;
    end else if (settle_q != SETTLE_CYC[15:0]) begin
      settle_q <= settle_q + 16'h0001;
    end
  end

  // The transmit selection alone tells the three states apart.
  assign tx_select_square_fill = (state_q == slrc_pkg::SLRC_ACQUIRE);
  assign tx_select_ready_fill  = (state_q == slrc_pkg::SLRC_WAIT_PEER);
  assign tx_select_data        = (state_q == slrc_pkg::SLRC_SEND_DATA);
  assign hs_enable             = tx_select_data;
  assign conn_ready_enable     = tx_select_data && settle_q == SETTLE_CYC[15:0];

  a_single_select: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot({tx_select_square_fill, tx_select_ready_fill, tx_select_data}))
    else $error("transmit selection not one-hot");
  a_wait_needs_qual: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_select_ready_fill) |-> $past(qual_cnt_q) == QUAL_FRAMES[7:0])
    else $error("left acquire without qualification");
  a_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_select_ready_fill) |-> $past(lock_cnt_q) == QUAL_FRAMES[7:0])
    else $error("square fill not held after lock");
  a_settle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_select_data) |-> !conn_ready_enable [*8])
    else $error("connect enabled too early");
  a_data_exit: assert property (@(posedge aclk) disable iff (!aresetn || restart)
    tx_select_data && err_reset |=> tx_select_square_fill)
    else $error("error did not return to acquire");
  a_gate_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !tx_select_data |-> !hs_enable && !conn_ready_enable)
    else $error("handshake open outside data state");
endmodule

//--- tb/slrc_peer_model.sv
// Behavioural model of the remote link controllers, one instance covering all link pairs.
// Assumes the local transmit selects are one-hot per pair and frames last two aclk cycles.
`timescale 1ns/1ps
module slrc_peer_model #(
  parameter int unsigned PAIRS = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [PAIRS-1:0] tx_select_square_fill,
  input  wire logic [PAIRS-1:0] peer_go,
  input  wire logic [PAIRS-1:0] err_inj,
  output logic      [PAIRS-1:0] frame_valid,
  output logic      [PAIRS-1:0] data_frame_seen,
  output logic      [PAIRS-1:0] square_fill_seen,
  output logic      [PAIRS-1:0] ready_fill_seen,
  output logic      [PAIRS-1:0] frame_error_seen
);
  logic phase_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q          <= 1'h0;
      frame_valid      <= '0;
      data_frame_seen  <= '0;
      square_fill_seen <= '0;
      ready_fill_seen  <= '0;
      frame_error_seen <= '0;
    end else begin
      phase_q <= ~phase_q;
      for (int p = 0; p < PAIRS; p++) begin
        frame_valid[p] <= ~phase_q;
        if (phase_q) begin
          // Between frames the type lines flip so a stale value is never mistaken for a frame.
          data_frame_seen[p]  <= ~data_frame_seen[p];
          square_fill_seen[p] <= ~square_fill_seen[p];
          ready_fill_seen[p]  <= ~ready_fill_seen[p];
          frame_error_seen[p] <= ~frame_error_seen[p];
        end else begin
          // A remote end that is not ready keeps sending square fill; a ready one answers.
          frame_error_seen[p] <= err_inj[p];
          square_fill_seen[p] <= !err_inj[p] && !peer_go[p];
          ready_fill_seen[p]  <= !err_inj[p] && peer_go[p] && tx_select_square_fill[p];
          data_frame_seen[p]  <= !err_inj[p] && peer_go[p] && !tx_select_square_fill[p];
        end
      end
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the serial link reset controller with two link pairs.
// Assumes the remote ends are modelled by slrc_peer_model and registers sit on AXI4-Lite.
`timescale 1ns/1ps
`include "slrc_defines.svh"
module testbench;
  localparam int P = 2;
  logic         aclk = 1'h0;
  logic         aresetn = 1'h0;
  logic [P-1:0] tx_multiplier_unlocked = 2'h3;
  logic [P-1:0] hs_in_connect = 2'h3;
  logic [P-1:0] hs_in_ready = 2'h3;
  logic [P-1:0] peer_go = 2'h1;
  logic [P-1:0] err_inj = 2'h0;
  logic         rand_hs = 1'h0;
  logic [31:0]  s_axil_awaddr = 32'h0;
  logic         s_axil_awvalid = 1'h0;
  logic [31:0]  s_axil_wdata = 32'h0;
  logic [3:0]   s_axil_wstrb = 4'hF;
  logic         s_axil_wvalid = 1'h0;
  logic         s_axil_bready = 1'h0;
  logic [31:0]  s_axil_araddr = 32'h0;
  logic         s_axil_arvalid = 1'h0;
  logic         s_axil_rready = 1'h0;
  logic [P-1:0] frame_valid, data_frame_seen, square_fill_seen, ready_fill_seen, frame_error_seen;
  logic [P-1:0] tx_select_square_fill, tx_select_ready_fill, tx_select_data;
  logic [P-1:0] hs_out_connect, hs_out_ready, hs_in_connect_gated, hs_in_ready_gated;
  logic         irq, s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0]   s_axil_bresp, s_axil_rresp;
  logic [31:0]  s_axil_rdata, d;
  logic [1:0]   r;
  logic         bad;
  int           n;
  int           err_count = 0;
  int           n_checks = 0;

  always #5 aclk = ~aclk;

  slrc_top #(.PAIRS(P)) i_slrc_top (
    .aclk, .aresetn, .frame_valid, .data_frame_seen, .square_fill_seen, .ready_fill_seen,
    .frame_error_seen, .tx_multiplier_unlocked, .tx_select_square_fill, .tx_select_ready_fill,
    .tx_select_data, .hs_in_connect, .hs_in_ready, .hs_out_connect, .hs_out_ready,
    .hs_in_connect_gated, .hs_in_ready_gated, .irq, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready
  );

  slrc_peer_model #(.PAIRS(P)) i_slrc_peer_model (
    .aclk, .aresetn, .tx_select_square_fill, .peer_go, .err_inj, .frame_valid,
    .data_frame_seen, .square_fill_seen, .ready_fill_seen, .frame_error_seen
  );

  always @(posedge aclk) begin
    if (rand_hs) begin
      hs_in_connect <= P'($urandom);
      hs_in_ready   <= P'($urandom);
    end
  end

  function automatic logic [2:0] exp_sel(input int st);
    return 3'h1 << st;
  endfunction

  function automatic logic [2:0] sel(input int p);
    return {tx_select_data[p], tx_select_ready_fill[p], tx_select_square_fill[p]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Waits for the answer however long it takes; only the watchdog ends a hang.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axil_awaddr  <= a;
    s_axil_awvalid <= 1'h1;
    s_axil_wdata   <= v;
    s_axil_wvalid  <= 1'h1;
    s_axil_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axil_awready === 1'h1) s_axil_awvalid <= 1'h0;
      if (s_axil_wready === 1'h1) s_axil_wvalid <= 1'h0;
    end while (s_axil_bvalid !== 1'h1);
    r = s_axil_bresp;
    s_axil_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axil_arready === 1'h1) s_axil_arvalid <= 1'h0;
    end while (s_axil_rvalid !== 1'h1);
    v = s_axil_rdata;
    rs = s_axil_rresp;
    s_axil_rready <= 1'h0;
  endtask

  // Polls at the falling edge until pair p shows state st or the limit runs out.
  task automatic wait_sel(input int p, input int st, input int lim, output int cnt);
    cnt = 0;
    @(negedge aclk);
    while (sel(p) !== exp_sel(st) && cnt < lim) begin
      @(negedge aclk);
      cnt++;
    end
    chk("tx_select", sel(p), exp_sel(st));
  endtask

  task automatic errs(input int frames);
    @(posedge aclk);
    err_inj <= 2'h1;
    repeat (2 * frames) @(posedge aclk);
    err_inj <= 2'h0;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    void'($urandom(15962));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk("square_fill", tx_select_square_fill, 2'h3);
    chk("irq", irq, 1'h0);
    axi_rd(`SLRC_OFF_STATE, d, r);
    chk("state_reg", d, 32'h0);
    chk("state_resp", r, 2'h0);
    axi_rd(`SLRC_OFF_IRQ_MASK, d, r);
    chk("mask_reg", d, `SLRC_MASK_RESET);
    axi_rd(32'h0000_0010, d, r);
    chk("unmapped_resp", r, 2'h2);
    chk("unmapped_data", d, 32'h0);
    axi_wr(32'h0000_0010, 32'h0);
    chk("unmapped_bresp", r, 2'h2);
    repeat (300 + $urandom_range(0, 50)) @(posedge aclk);
    chk("unlocked_hold", sel(0), exp_sel(0));
    $display("test reset_regs done");
    tx_multiplier_unlocked <= 2'h0;
    wait_sel(0, 1, 3000, n);
    chk("qualify_len", n >= 2 * `SLRC_QUAL_FRAMES, 1'h1);
    chk("wait_hs_out", {hs_out_connect, hs_out_ready}, 4'h0);
    chk("wait_hs_gated", {hs_in_connect_gated, hs_in_ready_gated}, 4'h0);
    wait_sel(0, 2, 200, n);
    chk("pair1_acquire", sel(1), exp_sel(0));
    bad = 1'h0;
    repeat (1990) begin
      @(negedge aclk);
      bad = bad | hs_out_connect[0] | hs_out_ready[0];
    end
    chk("settle_hs_out", bad, 1'h0);
    repeat (20) @(posedge aclk);
    rand_hs <= 1'h1;
    repeat (40) begin
      @(negedge aclk);
      chk("hs_out_connect", hs_out_connect, hs_in_connect & 2'h1);
      chk("hs_in_ready_gated", hs_in_ready_gated, hs_in_ready & 2'h1);
      chk("hs_out_ready", hs_out_ready, hs_in_ready & 2'h1);
      chk("hs_in_connect_gated", hs_in_connect_gated, hs_in_connect & 2'h1);
    end
    axi_rd(`SLRC_OFF_STATE, d, r);
    chk("state_reg", d, 32'h2);
    $display("test bring_up done");
    axi_wr(`SLRC_OFF_IRQ_MASK, 32'h9);
    chk("mask_bresp", r, 2'h0);
    errs(1);
    repeat (10) @(negedge aclk);
    chk("single_error", sel(0), exp_sel(2));
    chk("irq_quiet", irq, 1'h0);
    errs(2);
    wait_sel(0, 0, 20, n);
    axi_rd(`SLRC_OFF_IRQ_STAT, d, r);
    chk("stat_err_restart", d[3], 1'h1);
    chk("irq_set", irq, 1'h1);
    axi_wr(`SLRC_OFF_IRQ_STAT, 32'hFFFF_FFFF);
    axi_rd(`SLRC_OFF_IRQ_STAT, d, r);
    chk("stat_cleared", d, 32'h0);
    chk("irq_clear", irq, 1'h0);
    $display("test frame_errors done");
    axi_wr(`SLRC_OFF_IRQ_MASK, 32'h0);
    wait_sel(0, 2, 1000, n);
    axi_rd(`SLRC_OFF_IRQ_STAT, d, r);
    chk("stat_entries", d[2:1], 2'h3);
    repeat ($urandom_range(5, 40)) @(posedge aclk);
    tx_multiplier_unlocked <= 2'h1;
    wait_sel(0, 0, 20, n);
    axi_rd(`SLRC_OFF_IRQ_STAT, d, r);
    chk("stat_return", d[0], 1'h1);
    chk("irq_masked", irq, 1'h0);
    tx_multiplier_unlocked <= 2'h0;
    wait_sel(0, 2, 1000, n);
    peer_go <= 2'h0;
    wait_sel(0, 0, 20, n);
    peer_go <= 2'h1;
    wait_sel(0, 2, 1000, n);
    axi_wr(`SLRC_OFF_CTRL, 32'h1);
    wait_sel(0, 0, 10, n);
    axi_rd(`SLRC_OFF_CTRL, d, r);
    chk("ctrl_reads_zero", d, 32'h0);
    $display("test returns done");
    peer_go <= 2'h3;
    wait_sel(1, 2, 3000, n);
    axi_rd(`SLRC_OFF_STATE, d, r);
    chk("state_reg", d[3:2], 2'h2);
    $display("test pair_two done");
    test_done();
  end
endmodule
